// ==== shared/ptimer_pkg.sv ====
// Constants for the 10-bit periodic timer: register map, fields, resets.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
package ptimer_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_CTRL1    = 8'h04;
  localparam logic [7:0] OFS_CNT_LO   = 8'h08;
  localparam logic [7:0] OFS_CNT_HI   = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO  = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI  = 8'h14;
  localparam logic [7:0] OFS_PER_LO   = 8'h18;
  localparam logic [7:0] OFS_PER_HI   = 8'h1c;
  localparam logic [7:0] OFS_FLAGS    = 8'h20;
  // Field positions.
  localparam int RUN_BIT     = 3;
  localparam int CLR_SEL_BIT = 0;
  localparam int CAP_SRC_BIT = 1;
  localparam int INV_BIT     = 2;
  localparam int INIT_BIT    = 3;
  localparam int PF_LSB      = 4;
  localparam int MODE_LSB    = 6;
  localparam int FLAG_A_BIT  = 0;
  localparam int FLAG_P_BIT  = 1;
  // Reset values and counter maximum.
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] VAL_RST   = 10'h000;
  localparam logic [9:0] CNT_MAX   = 10'h3ff;
  // Mode codes.
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC  = 2'h3;
  // Pin function codes.
  localparam logic [1:0] PF_00 = 2'h0;
  localparam logic [1:0] PF_01 = 2'h1;
  localparam logic [1:0] PF_10 = 2'h2;
  localparam logic [1:0] PF_11 = 2'h3;
endpackage

// ==== core/periodic_timer.sv ====
// 10-bit periodic timer with compare, PWM, single pulse and capture modes.
// Assumes one AHB-Lite master, pins arriving asynchronously to hclk, and
// a counter that advances on every hclk edge while running.
//
// Behaviour
// - Clear-select low: P match clears, both flags
// - Clear-select high: A match clears, no P flag
// - Compare A zero: overflow at 3FF, no A flag
// - Pin changes only on A match, per function, and on run rise
// - Run rising edge loads initial pin level
// - Timer/counter mode: compare behaviour, pin released
// - PWM period equals value, zero gives 1024
// - Duty not below period gives full duty
// - PWM flags, polarity, inversion and forced levels
// - PWM counting continues under forced levels
// - Single pulse: run rise starts the pulse
// - External clock edge sets the run bit
// - A match or software clear ends pulse
// - Single pulse: counter zeroed only on run rise
// - Capture source select; run rise starts count
// - Active edge copies counter into compare A
// - Capture: P match clears counter, raises flag
// - Pin function 11 disables capture only
// - Values split low byte, high two bits
// - Run rise zeroes counter; fall holds it
`timescale 1ns/1ps
module periodic_timer (
  // Bus clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External pins.
  input  wire logic        external_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_out,
  output logic             timer_out_en_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0] ctrl1_r;        // Mode, pin function and option bits.
  logic       run_r;          // The counter run bit.
  logic       run_d_r;        // Run bit one cycle ago, for edge detect.
  logic [9:0] cnt_r;          // The counter.
  logic [9:0] cmpa_r;         // Compare A value.
  logic [9:0] per_r;          // Period value.
  logic       flag_a_r;       // Sticky match A flag.
  logic       flag_p_r;       // Sticky match P flag.
  logic       out_r;          // Compare-mode pin state before inversion.
  logic [2:0] ck_s_r;         // External clock pin sync and history.
  logic [2:0] pi_s_r;         // Capture pin sync and history.
  logic       wr_pend_r;      // Data phase of a write is pending.
  logic [7:0] wr_addr_r;      // Address latched for that write.
  logic [31:0] rdata_r;       // Read data captured at the address phase.

  logic [1:0] mode;
  logic [1:0] pf;
  logic       clr_sel;
  logic       init_lvl;
  logic       inv;
  logic       run_rise;
  logic [9:0] cnt_inc;
  logic       a_hit;
  logic       p_hit;
  logic       single;
  logic       ck_rise;
  logic       cap_evt;
  logic       wr_a_clr;
  logic       wr_p_clr;
  logic       addr_ok;
  logic [10:0] per_eff;
  logic       pwm_act;

  assign mode     = ctrl1_r[ptimer_pkg::MODE_LSB +: 2];
  assign pf       = ctrl1_r[ptimer_pkg::PF_LSB +: 2];
  assign clr_sel  = ctrl1_r[ptimer_pkg::CLR_SEL_BIT];
  assign init_lvl = ctrl1_r[ptimer_pkg::INIT_BIT];
  assign inv      = ctrl1_r[ptimer_pkg::INV_BIT];
  assign single   = (mode == ptimer_pkg::MODE_PWM) && (pf == ptimer_pkg::PF_11);

  // Write decode shared by several processes.
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_pend_r && (wr_addr_r == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare logic.

  // Matching against count+1 makes a value of N give N clocks per cycle,
  // and a zero value fall out naturally as a 1024-clock overflow.
  assign cnt_inc  = cnt_r + 10'h001;
  assign run_rise = run_r && !run_d_r;
  assign a_hit    = run_r && !run_rise && (cnt_inc == cmpa_r)
                    && (cmpa_r != ptimer_pkg::VAL_RST);
  assign p_hit    = run_r && !run_rise && (cnt_inc == per_r);

  // Pin edge detection reads only the second and third sync stages.
  assign ck_rise = ck_s_r[1] && !ck_s_r[2];

  // Capture trigger: source and edge selection, pin function 11 disables.
  always_comb
  begin
    logic nw;
    logic od;
    nw = ctrl1_r[ptimer_pkg::CAP_SRC_BIT] ? ck_s_r[1] : pi_s_r[1];
    od = ctrl1_r[ptimer_pkg::CAP_SRC_BIT] ? ck_s_r[2] : pi_s_r[2];
    case (pf)
      ptimer_pkg::PF_00: cap_evt = nw && !od;
      ptimer_pkg::PF_01: cap_evt = !nw && od;
      ptimer_pkg::PF_10: cap_evt = nw != od;
      default:           cap_evt = 1'b0;
    endcase
    if ((mode != ptimer_pkg::MODE_CAP) || !run_r)
    begin
      cap_evt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Two flops before use; the third only remembers the previous level.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ck_s_r <= 3'h0;
      pi_s_r <= 3'h0;
    end
    else
    begin
      ck_s_r <= {ck_s_r[1:0], external_clock_pin};
      pi_s_r <= {pi_s_r[1:0], capture_input_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, OKAY always.

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign addr_ok   = hsel && hready && htrans[1];

  // Address phase: latch write target, sample read data for data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr;
      rdata_r   <= 32'h0000_0000;
      if (addr_ok && !hwrite)
      begin
        // High registers show bits 9..8 only; the rest read zero.
        case (haddr)
          ptimer_pkg::OFS_CTRL0:   rdata_r[ptimer_pkg::RUN_BIT] <= run_r;
          ptimer_pkg::OFS_CTRL1:   rdata_r[7:0] <= ctrl1_r;
          ptimer_pkg::OFS_CNT_LO:  rdata_r[7:0] <= cnt_r[7:0];
          ptimer_pkg::OFS_CNT_HI:  rdata_r[1:0] <= cnt_r[9:8];
          ptimer_pkg::OFS_CMPA_LO: rdata_r[7:0] <= cmpa_r[7:0];
          ptimer_pkg::OFS_CMPA_HI: rdata_r[1:0] <= cmpa_r[9:8];
          ptimer_pkg::OFS_PER_LO:  rdata_r[7:0] <= per_r[7:0];
          ptimer_pkg::OFS_PER_HI:  rdata_r[1:0] <= per_r[9:8];
          ptimer_pkg::OFS_FLAGS:   rdata_r[1:0] <= {flag_p_r, flag_a_r};
          default:                 rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Mode bits are plain storage; software stops the timer before changes.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl1_r <= ptimer_pkg::CTRL1_RST;
      per_r   <= ptimer_pkg::VAL_RST;
    end
    else
    begin
      if (wr_hit(ptimer_pkg::OFS_CTRL1))
      begin
        ctrl1_r <= hwdata[7:0];
      end
      if (wr_hit(ptimer_pkg::OFS_PER_LO))
      begin
        per_r[7:0] <= hwdata[7:0];
      end
      if (wr_hit(ptimer_pkg::OFS_PER_HI))
      begin
        per_r[9:8] <= hwdata[1:0];
      end
    end
  end

  // Compare A: software writes, but a capture in the same cycle wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmpa_r <= ptimer_pkg::VAL_RST;
    end
    else if (cap_evt)
    begin
      cmpa_r <= cnt_r;
    end
    else
    begin
      if (wr_hit(ptimer_pkg::OFS_CMPA_LO))
      begin
        cmpa_r[7:0] <= hwdata[7:0];
      end
      if (wr_hit(ptimer_pkg::OFS_CMPA_HI))
      begin
        cmpa_r[9:8] <= hwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run bit.

  // Hardware set and clear win over a software write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r   <= 1'b0;
      run_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= run_r;
      if (single && run_r && a_hit)
      begin
        run_r <= 1'b0;
      end
      else if (single && ck_rise)
      begin
        run_r <= 1'b1;
      end
      else if (wr_hit(ptimer_pkg::OFS_CTRL0))
      begin
        run_r <= hwdata[ptimer_pkg::RUN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  // Zeroed on a run rise, held while stopped, cleared per mode.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= ptimer_pkg::VAL_RST;
    end
    else if (run_rise)
    begin
      cnt_r <= ptimer_pkg::VAL_RST;
    end
    else if (run_r)
    begin
      cnt_r <= cnt_inc;
      case (mode)
        ptimer_pkg::MODE_CMP, ptimer_pkg::MODE_TC:
        begin
          // Overflow wraps by itself when the chosen value is zero.
          if (clr_sel ? a_hit : p_hit)
          begin
            cnt_r <= ptimer_pkg::VAL_RST;
          end
        end
        ptimer_pkg::MODE_PWM:
        begin
          // Single pulse free-runs; only PWM clears on the period.
          if (!single && p_hit)
          begin
            cnt_r <= ptimer_pkg::VAL_RST;
          end
        end
        default:
        begin
          if (p_hit)
          begin
            cnt_r <= ptimer_pkg::VAL_RST;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match flags, write one to clear.

  assign wr_a_clr = wr_hit(ptimer_pkg::OFS_FLAGS) && hwdata[ptimer_pkg::FLAG_A_BIT];
  assign wr_p_clr = wr_hit(ptimer_pkg::OFS_FLAGS) && hwdata[ptimer_pkg::FLAG_P_BIT];

  // An event in the clearing cycle keeps the flag set.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end
    else
    begin
      flag_a_r <= (flag_a_r && !wr_a_clr) || a_hit || cap_evt;
      flag_p_r <= (flag_p_r && !wr_p_clr) || (p_hit && !single
                  && !(clr_sel && (mode == ptimer_pkg::MODE_CMP
                  || mode == ptimer_pkg::MODE_TC)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin.

  // Compare-mode pin state: initial level on run rise, action on A match.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_r <= 1'b0;
    end
    else if (run_rise)
    begin
      out_r <= init_lvl;
    end
    else if (a_hit && (mode == ptimer_pkg::MODE_CMP))
    begin
      case (pf)
        ptimer_pkg::PF_01: out_r <= 1'b0;
        ptimer_pkg::PF_10: out_r <= 1'b1;
        ptimer_pkg::PF_11: out_r <= !out_r;
        default:           out_r <= out_r;
      endcase
    end
  end

  // Duty is full whenever compare A reaches the effective period.
  assign per_eff = (per_r == ptimer_pkg::VAL_RST) ? 11'h400 : {1'b0, per_r};
  assign pwm_act = ({1'b0, cmpa_r} >= per_eff) || (cnt_r < cmpa_r);

  // Pin level per mode; inversion applies last.
  always_comb
  begin
    timer_out_en_n = 1'b0;
    timer_out      = 1'b0;
    case (mode)
      ptimer_pkg::MODE_CMP: timer_out = out_r ^ inv;
      ptimer_pkg::MODE_PWM:
      begin
        case (pf)
          ptimer_pkg::PF_00: timer_out = !init_lvl ^ inv;
          ptimer_pkg::PF_01: timer_out = init_lvl ^ inv;
          ptimer_pkg::PF_10: timer_out = (pwm_act ? init_lvl : !init_lvl) ^ inv;
          default:           timer_out = (run_r ? init_lvl : !init_lvl) ^ inv;
        endcase
      end
      default: timer_out_en_n = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cmp_running;
    (mode == ptimer_pkg::MODE_CMP) && run_r && !run_rise;
  endsequence

  property p_flag_a_set;
    s_cmp_running ##0 a_hit |=> flag_a_r;
  endproperty
  a_flag_a_set: assert property (p_flag_a_set) else $error("A flag missed");

  property p_no_pflag;
    s_cmp_running ##0 clr_sel && !flag_p_r && !wr_p_clr |=> !flag_p_r;
  endproperty
  a_no_pflag: assert property (p_no_pflag) else $error("P flag raised");

  // Compare A zero is legal in timer/counter mode too, so the overflow
  // is watched there as well as in compare mode.
  property p_overflow;
    (mode == ptimer_pkg::MODE_CMP || mode == ptimer_pkg::MODE_TC) && run_r
      && !run_rise && clr_sel && cmpa_r == ptimer_pkg::VAL_RST
      && cnt_r == ptimer_pkg::CNT_MAX
      |=> cnt_r == ptimer_pkg::VAL_RST && !$rose(flag_a_r);
  endproperty
  a_overflow: assert property (p_overflow) else $error("Bad overflow");

  property p_pin_hold;
    (mode == ptimer_pkg::MODE_CMP) && !a_hit && !run_rise |=> $stable(out_r);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("Pin moved");

  property p_init_level;
    run_rise ##1 $stable(ctrl1_r) |-> out_r == $past(init_lvl);
  endproperty
  a_init_level: assert property (p_init_level) else $error("Init level");

  property p_tc_release;
    mode == ptimer_pkg::MODE_TC |-> timer_out_en_n;
  endproperty
  a_tc_release: assert property (p_tc_release) else $error("Pin driven");

  property p_full_duty;
    mode == ptimer_pkg::MODE_PWM && pf == ptimer_pkg::PF_10
      && {1'b0, cmpa_r} >= per_eff |-> timer_out == (init_lvl ^ inv);
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("Duty not full");

  property p_sp_end;
    single && run_r && a_hit |=> !run_r ##1 $stable(cnt_r);
  endproperty
  a_sp_end: assert property (p_sp_end) else $error("Pulse not ended");

  property p_capture;
    cap_evt |=> cmpa_r == $past(cnt_r) && flag_a_r;
  endproperty
  a_capture: assert property (p_capture) else $error("Capture lost");

  property p_run_zero;
    run_rise |=> cnt_r == 10'h000;
  endproperty
  a_run_zero: assert property (p_run_zero) else $error("No zeroing");

endmodule // periodic_timer

// ==== verif/pin_model.sv ====
// Far-side model: two pin sources and a pulled-down load on the timer pin.
// Assumes the bench calls drive() and that pins move after a rising edge.
`timescale 1ns/1ps
module pin_model (
  // Clock.
  input  wire logic hclk,
  // Timer pin as the block drives it.
  input  wire logic timer_out,
  input  wire logic timer_out_en_n,
  // Signal sources.
  output logic      external_clock_pin,
  output logic      capture_input_pin,
  // Level on the board net.
  output logic      pin_level
);
  // A pull-down owns the net once the block lets go, so no stale level.
  assign pin_level = timer_out_en_n ? 1'b0 : timer_out;

  // Both sources idle low.
  initial
  begin
    external_clock_pin = 1'b0;
    capture_input_pin  = 1'b0;
  end

  // Move one source just after an edge, then hold it for some cycles.
  task automatic drive(input logic sel, input logic v, input int hold);
    @(posedge hclk);
    if (sel)
      external_clock_pin <= v;
    else
      capture_input_pin <= v;
    repeat (hold) @(posedge hclk);
  endtask
endmodule // pin_model

// ==== verif/testbench.sv ====
// Self-checking bench for the periodic timer.
// Assumes a zero-wait AHB-Lite slave and the pin model beside it.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] C0 = ptimer_pkg::OFS_CTRL0;
  localparam logic [7:0] C1 = ptimer_pkg::OFS_CTRL1;
  localparam logic [7:0] CL = ptimer_pkg::OFS_CNT_LO;
  localparam logic [7:0] CA = ptimer_pkg::OFS_CMPA_LO;
  localparam logic [7:0] CP = ptimer_pkg::OFS_PER_LO;
  localparam logic [7:0] FL = ptimer_pkg::OFS_FLAGS;
  localparam logic [31:0] RUN = 32'h1 << ptimer_pkg::RUN_BIT;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, seed;
  logic        timer_out, timer_out_en_n, pin_level;
  logic        external_clock_pin, capture_input_pin;
  logic [9:0]  c1, c2;
  int          err_count, n_compared, k, p, a, d, h, n, hi;
  int          cyc = 0;

  // The slave's own ready closes the bus loop.
  periodic_timer periodic_timer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_clock_pin(external_clock_pin),
    .capture_input_pin(capture_input_pin), .timer_out(timer_out),
    .timer_out_en_n(timer_out_en_n));
  pin_model pin_model_inst (
    .hclk(hclk), .timer_out(timer_out), .timer_out_en_n(timer_out_en_n),
    .external_clock_pin(external_clock_pin),
    .capture_input_pin(capture_input_pin), .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // A hang ends the run as a failure.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Control byte in the order mode, pin function, level, invert, src, clr.
  function automatic logic [7:0] cfg(input logic [1:0] m, input logic [1:0] f,
                                      input logic [3:0] b);
    return {m, f, b};
  endfunction

  // Pin level after one comparator A match, per pin function code.
  function automatic logic pin_exp(input int f, input logic ini);
    return (f == 0) ? ini : (f == 3) ? ~ini : (f == 2);
  endfunction

  // Active cycles in two periods; full duty once duty reaches the period.
  function automatic int pwm_exp(input int n, input int d, input logic inv);
    int base;
    base = (d >= n) ? 2 * n : 2 * d;
    return inv ? 2 * n - base : base;
  endfunction

  task automatic rnd(input int lo, input int span, output int v);
    repeat (8) seed = lfsr(seed);
    v = lo + int'(seed[15:0]) % span;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single transfer; read data is taken at the data phase's edge.
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    bus(ad, 1'b1, v);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] ad,
                       input logic [31:0] e);
    bus(ad, 1'b0, 32'h0);
    check(nm, rd, e);
  endtask

  // Ten-bit values live as a low byte and a two-bit high word.
  task automatic set10(input logic [7:0] ad, input logic [9:0] v);
    wr(ad, {24'h0, v[7:0]});
    wr(ad + 8'h4, {30'h0, v[9:8]});
  endtask

  task automatic get10(input logic [7:0] ad, output logic [9:0] v);
    bus(ad, 1'b0, 32'h0);
    v[7:0] = rd[7:0];
    bus(ad + 8'h4, 1'b0, 32'h0);
    v[9:8] = rd[1:0];
  endtask

  // Mode changes only while stopped; flags are cleared before the start.
  task automatic setup(input logic [7:0] c, input int av, input int pv,
                       input logic go);
    wr(C0, 32'h0);
    wr(C1, {24'h0, c});
    set10(CA, 10'(av));
    set10(CP, 10'(pv));
    wr(FL, 32'h3);
    if (go)
      wr(C0, RUN);
  endtask

  task automatic highs(input int cnt, output int hv);
    hv = 0;
    repeat (cnt)
    begin
      @(posedge hclk);
      if (pin_level === 1'b1)
        hv++;
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    seed = 32'h0001_0d50;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, an unmapped word and the empty upper bits.
    for (k = 0; k < 4; k++)
      rdchk("value reset", CA + 8'(4 * k), 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
    check("bus response", hresp, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      rnd(0, 256, a);
      wr(CA + 8'(8 * k), 32'hffffff00 | 32'(a));
      wr(CA + 8'(8 * k + 4), 32'hffffffff);
      rdchk("low byte", CA + 8'(8 * k), 32'(a));
      rdchk("high bits", CA + 8'(8 * k + 4), 32'h3);
    end
    // Compare mode: exactly one A match seen, for each pin function.
    for (k = 0; k < 4; k++)
    begin
      rnd(40, 64, p);
      a = p / 4;
      rnd(0, 2, hi);
      setup(cfg(ptimer_pkg::MODE_CMP, 2'(k), {hi[0], 3'h0}), a, p, 1'b1);
      repeat (2) @(posedge hclk);
      check("initial level", pin_level, hi[0]);
      repeat (p + a / 2) @(posedge hclk);
      check("pin after match", pin_level, pin_exp(k, hi[0]));
      rdchk("flags on period", FL, 32'h3);
      bus(CL, 1'b0, 32'h0);
      check("count below period", rd < p, 1'b1);
    end
    wr(C0, 32'h0);
    wr(FL, 32'h3);
    rdchk("flags cleared", FL, 32'h0);
    get10(CL, c1);
    repeat (20) @(posedge hclk);
    rdchk("count held", CL, 32'(c1[7:0]));
    // Clear on A with the period below it: no P flag.
    rnd(60, 64, a);
    setup(cfg(ptimer_pkg::MODE_CMP, 2'h0, 4'h1), a, a / 2, 1'b1);
    repeat (3 * a) @(posedge hclk);
    rdchk("flags clear on a", FL, 32'h1);
    bus(CL, 1'b0, 32'h0);
    check("count below a", rd < a, 1'b1);
    // Timer/counter with zero compares: pin released, full overflow.
    for (k = 0; k < 2; k++)
    begin
      setup(cfg(ptimer_pkg::MODE_TC, 2'h2, {3'h4, k[0]}), 0, 0, 1'b1);
      check("pin released", timer_out_en_n, 1'b1);
      repeat (1100) @(posedge hclk);
      rdchk("overflow flags", FL, 32'(2 - 2 * k));
      get10(CL, c1);
      check("wrapped count", c1 < 10'h080, 1'b1);
    end
    // PWM: random period and duty, full duty, inversion, zero period.
    for (k = 0; k < 6; k++)
    begin
      rnd(16, 128, p);
      rnd(0, p + 24, d);
      if (k == 4)
        d = p;
      if (k == 5)
      begin
        p = 0;
        d = 256;
      end
      hi = k % 2;
      setup(cfg(ptimer_pkg::MODE_PWM, 2'h2, {1'b1, hi[0], 2'b01}), d, p,
            1'b1);
      n = (p == 0) ? 1024 : p;
      repeat (n + 4) @(posedge hclk);
      highs(2 * n, h);
      check("pwm active cycles", h, pwm_exp(n, d, hi[0]));
    end
    // Forced levels keep the counter and comparators going.
    for (k = 0; k < 2; k++)
    begin
      setup(cfg(ptimer_pkg::MODE_PWM, 2'(k), 4'h8), 20, 50, 1'b1);
      highs(100, h);
      check("forced level", h, 100 * k);
      rdchk("forced flags", FL, 32'h3);
    end
    // Single pulse from a pin edge; a short period must not matter.
    rnd(20, 64, a);
    setup(cfg(ptimer_pkg::MODE_PWM, 2'h3, 4'h8), a, 5, 1'b0);
    fork
      pin_model_inst.drive(1'b1, 1'b1, 4);
      highs(a + 60, h);
    join
    check("pulse width", h >= a && h <= a + 2, 1'b1);
    rdchk("run cleared", C0, 32'h0);
    bus(FL, 1'b0, 32'h0);
    check("pulse flag", rd[0], 1'b1);
    get10(CL, c1);
    repeat (30) @(posedge hclk);
    rdchk("pulse count held", CL, 32'(c1[7:0]));
    pin_model_inst.drive(1'b1, 1'b0, 2);
    wr(C0, RUN);
    repeat (2) @(posedge hclk);
    check("leading edge", pin_level, 1'b1);
    wr(C0, 32'h0);
    repeat (2) @(posedge hclk);
    check("trailing edge", pin_level, 1'b0);
    // Capture: every edge code, both sources, the other pin as a decoy.
    for (k = 0; k < 4; k++)
    begin
      setup(cfg(ptimer_pkg::MODE_CAP, 2'(k), {2'b00, k[0], 1'b0}), 0, 0,
            1'b1);
      pin_model_inst.drive(~k[0], 1'b1, 4);
      pin_model_inst.drive(~k[0], 1'b0, 40);
      pin_model_inst.drive(k[0], 1'b1, 20);
      get10(CA, c1);
      pin_model_inst.drive(k[0], 1'b0, 20);
      get10(CA, c2);
      check("rise capture", c1 != 0, k == 0 || k == 2);
      check("fall capture", c2 != c1, k == 1 || k == 2);
      check("capture source", c1 == 0 || c1 >= 40, 1'b1);
      bus(FL, 1'b0, 32'h0);
      check("capture flag", rd[0], k != 3);
    end
    // Capture disabled; the period wraps the counter and flags it.
    rnd(30, 64, p);
    setup(cfg(ptimer_pkg::MODE_CAP, 2'h3, 4'h0), 0, p, 1'b1);
    repeat (300) @(posedge hclk);
    rdchk("capture wrap flag", FL, 32'h2);
    bus(CL, 1'b0, 32'h0);
    check("capture count", rd < p, 1'b1);
    complete_run();
  end
endmodule // testbench
